// file: bench/pmcfg_host.sv
`timescale 1ns/10ps
module pmcfg_host
   import pmcfg_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Byte request
   output pmcfg_req_t o_req
);
   logic [7:0] exp_q[$];
   initial o_req = '0;
   // Each call sets the request once and holds it to the taking edge
   task automatic op(input logic [8:0] a, input logic [7:0] d, input logic w, input logic r);
      o_req = '{a, d, w, r};
      @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      op(a, d, 1'b1, 1'b0);
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(a, 8'h00, 1'b0, 1'b1);
   endtask
   task automatic idle(input int n);
      repeat (n) op(9'h000, 8'h00, 1'b0, 1'b0);
   endtask
endmodule

// file: bench/pmcfg_regs_assertions.sv
`timescale 1ns/10ps
module pmcfg_regs_assertions
   import pmcfg_pkg::*;
(
   // Watched ports
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire pmcfg_req_t i_req,
   input wire logic o_rvalid,
   input wire logic [7:0] o_rdata,
   input wire logic o_hit,
   input wire logic [6:0] i_link_addr,
   input wire logic o_addr_match,
   input wire logic [6:0] o_target_addr,
   input wire logic i_b_selected,
   input wire logic [1:0] i_conv_operating_select,
   input wire logic i_irq_event,
   input wire logic o_irq_out_n_o,
   input wire logic o_irq_out_n_oe,
   input wire pmcfg_conv_mode_t o_conv_mode,
   input wire logic [PMCFG_NUM_LINREG-1:0] o_linreg_sleep
);
   logic [1:0] pin_r;
   logic irq_lvl;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Shadow of the polarity and drive bits
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pin_r <= 2'h0;
      end else if (i_ce && i_req.wr && i_req.addr == PMCFG_OFS_PIN_LINK) begin
         pin_r <= i_req.wdata[3:2];
      end
   end
   assign irq_lvl = i_irq_event ? pin_r[1] : !pin_r[1];
   // ==========================================================
   // Properties
   // ==========================================================
   sequence pins_steady;
      ($stable(pin_r) && $stable(i_irq_event) && i_ce) [*3];
   endsequence
   sequence opsel_held(logic [1:0] v);
      (i_conv_operating_select == v && i_ce) [*3];
   endsequence
   property p_forced(logic [1:0] v, logic [2:0] m);
      opsel_held(v) |-> o_conv_mode == m;
   endproperty
   a_read_answer: assert property (i_ce && i_req.rd |=> o_rvalid) else $error("no read answer");
   a_unmapped_zero: assert property (i_ce && i_req.rd && !o_hit |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_addr_pair: assert property (o_addr_match == (i_link_addr == o_target_addr || i_link_addr == 7'(o_target_addr + 7'h01)))
      else $error("address match wrong");
   a_addr_low_zero: assert property (o_target_addr[2:0] == 3'h0) else $error("address low bits");
   a_mode_sleep: assert property (p_forced(2'b01, 3'b100)) else $error("forced sleep wrong");
   a_mode_sync: assert property (p_forced(2'b10, 3'b010)) else $error("forced sync wrong");
   a_mode_auto: assert property (p_forced(2'b11, 3'b001)) else $error("auto mode wrong");
   a_lin_sleep_gate: assert property ((!i_b_selected && i_ce) [*3] |-> o_linreg_sleep == '0)
      else $error("regulator sleep without B");
   a_irq_drive: assert property (pins_steady |-> (pin_r[0] ?
      (!o_irq_out_n_o && o_irq_out_n_oe == !irq_lvl) : (o_irq_out_n_oe && o_irq_out_n_o == irq_lvl)))
      else $error("interrupt pin drive wrong");
endmodule

bind pmcfg_regs pmcfg_regs_assertions i_chk (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_req(i_req),
   .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_hit(o_hit), .i_link_addr(i_link_addr), .o_addr_match(o_addr_match),
   .o_target_addr(o_target_addr), .i_b_selected(i_b_selected), .i_conv_operating_select(i_conv_operating_select),
   .i_irq_event(i_irq_event), .o_irq_out_n_o(o_irq_out_n_o), .o_irq_out_n_oe(o_irq_out_n_oe),
   .o_conv_mode(o_conv_mode), .o_linreg_sleep(o_linreg_sleep));

// file: bench/tb_pmcfg_regs.sv
`timescale 1ns/10ps
module tb_pmcfg_regs
   import pmcfg_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic fuse = 1'b1;
   logic b_sel = 1'b0;
   logic [1:0] opsel = 2'h0;
   logic [6:0] link_addr;
   logic irq_ev;
   logic sys_rst;
   logic [6:0] exp_ta = 7'h28;
   logic ce_q = 1'b0;
   logic [1:0] pin_s = 2'h0;
   logic [31:0] seed = 32'h121A5340;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   pmcfg_req_t req;
   logic [7:0] rdata;
   logic rvalid, hit, match, hs, fp, ls, cs, irq_o, irq_oe, rst_o, rst_oe, c1, c2, c3, dis;
   logic [6:0] taddr;
   logic [11:0] hyst, thr, cmv;
   pmcfg_conv_mode_t cmode;
   logic [47:0] lmv;
   logic [3:0] lsl;
   logic [8:0] ofs [10] = '{9'h0B8, 9'h0B9, 9'h0BA, 9'h0BB, 9'h0BC, 9'h0BD, 9'h105, 9'h106, 9'h107, 9'h108};
   logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h02, 6'h38, 6'h39, 6'h3F};

   pmcfg_host i_pmcfg_host (.i_clk(clk), .o_req(req));
   pmcfg_regs i_pmcfg_regs (.i_clk(clk), .i_reset(reset), .i_ce(ce), .i_req(req), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_hit(hit), .i_link_addr(link_addr), .o_addr_match(match), .o_target_addr(taddr),
      .i_fuse_config_lock(fuse), .i_b_selected(b_sel), .i_conv_operating_select(opsel),
      .o_link_high_speed_fixed(hs), .o_link_fast_plus_timing(fp), .o_link_supply_select(ls),
      .o_control_input_supply_select(cs), .i_irq_event(irq_ev), .i_sys_reset_assert(sys_rst),
      .o_irq_out_n_o(irq_o), .o_irq_out_n_oe(irq_oe), .o_sys_reset_out_n_o(rst_o), .o_sys_reset_out_n_oe(rst_oe),
      .o_undervolt_hysteresis_mv(hyst), .o_undervolt_threshold_mv(thr), .o_conv_b_mv(cmv), .o_conv_mode(cmode),
      .o_conv1_clock_invert(c1), .o_conv2_clock_invert(c2), .o_conv3_clock_invert(c3),
      .o_rail_active_discharge(dis), .o_linreg_b_mv(lmv), .o_linreg_sleep(lsl));

   always #20 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // Monitor, random drive, timeout
   // ==========================================================
   // A read answer frozen by a low enable is the same answer, so take it once
   always @(posedge clk) begin
      if (rvalid === 1'b1 && ce_q) cmp("rdata", 12'(i_pmcfg_host.exp_q.pop_front()), 12'(rdata));
      if (!reset) cmp("addr_match", 12'(link_addr == exp_ta || link_addr == exp_ta + 7'h01), 12'(match));
      if (!reset) cmp("hit", 12'(req.addr inside {9'h0B8, [9'h0BA:9'h0BD], [9'h105:9'h108]}), 12'(hit));
      ce_q <= ce;
      pin_s <= {sys_rst, irq_ev};
   end
   // Pin events change rarely so the drive check gets quiet spans
   always @(posedge clk) begin
      #1;
      seed = lfsr(seed);
      if (seed[1:0] == 2'h0) irq_ev = seed[13];
      if (seed[5:4] == 2'h0) sys_rst = seed[17];
      link_addr = seed[3] ? {taddr[6:1], seed[21]} : seed[28:22];
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      logic [7:0] d;
      logic [5:0] lc;
      logic [2:0] m;
      logic lvl;
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      i_pmcfg_host.idle(2);
      cmp("target_addr", 12'h028, 12'(taddr));
      foreach (ofs[j]) i_pmcfg_host.rd(ofs[j], ofs[j] == 9'h105 ? 8'h50 : 8'h00);
      i_pmcfg_host.wr(9'h105, 8'hA7);
      i_pmcfg_host.rd(9'h105, 8'h50);
      fuse = 1'b0;
      i_pmcfg_host.wr(9'h105, 8'hA7);
      exp_ta = 7'h50;
      i_pmcfg_host.rd(9'h105, 8'hA0);
      i_pmcfg_host.idle(1);
      cmp("target_addr", 12'h050, 12'(taddr));
      for (int i = 0; i < 8; i++) begin
         d = {seed[9:8], i < 6 ? codes[i] : seed[5:0]};
         b_sel = seed[11];
         lc = d[5:0] < 6'h02 ? 6'h02 : d[5:0] > 6'h38 ? 6'h38 : d[5:0];
         i_pmcfg_host.wr(9'h0BA + 9'(i % 4), d);
         i_pmcfg_host.idle(2);
         cmp("linreg_mv", PMCFG_LIN_BASE_MV + 12'(lc - 6'h02) * PMCFG_LIN_STEP_MV, lmv[(i % 4) * 12 +: 12]);
         cmp("linreg_sleep", 12'(d[7] & b_sel), 12'(lsl[i % 4]));
         i_pmcfg_host.rd(9'h0BA + 9'(i % 4), d);
      end
      for (int i = 0; i < 8; i++) begin
         d = {i > 3, i == 0 ? 7'h00 : i == 1 ? 7'h7F : seed[6:0]};
         opsel = 2'(i % 4);
         b_sel = seed[12];
         m = opsel == 2'h0 ? (!b_sel ? 3'b000 : d[7] ? 3'b100 : 3'b010) :
            opsel == 2'h1 ? 3'b100 : opsel == 2'h2 ? 3'b010 : 3'b001;
         i_pmcfg_host.wr(9'h0B8, d);
         i_pmcfg_host.idle(2);
         cmp("conv_mv", PMCFG_CONV_BASE_MV + 12'(d[6:0]) * PMCFG_CONV_STEP_MV, cmv);
         cmp("conv_mode", 12'(m), 12'(cmode));
      end
      b_sel = 1'b0;
      opsel = 2'h0;
      i_pmcfg_host.idle(3);
      cmp("conv_mode", 12'h000, 12'(cmode));
      cmp("linreg_sleep", 12'h000, 12'(lsl));
      for (int i = 0; i < 4; i++) begin
         d = i == 0 ? 8'h00 : i == 1 ? 8'hFF : seed[7:0];
         i_pmcfg_host.wr(9'h107, d);
         i_pmcfg_host.wr(9'h108, d);
         i_pmcfg_host.wr(9'h106, {d[7:4], 2'(i), d[1:0]});
         i_pmcfg_host.idle(8);
         cmp("hysteresis", PMCFG_HYST_BASE_MV + 12'(d[6:4]) * PMCFG_FAULT_STEP_MV, hyst);
         cmp("threshold", PMCFG_FAULT_BASE_MV + 12'(d[3:0]) * PMCFG_FAULT_STEP_MV, thr);
         cmp("clk_cfg", 12'({d[3], d[6], d[4], d[2]}), 12'({c1, c2, c3, dis}));
         cmp("link_cfg", 12'({d[6:4], d[0]}), 12'({hs, fp, ls, cs}));
         // Pins follow the event levels taken at the last edge
         lvl = pin_s[0] ? i[1] : !i[1];
         cmp("irq_pin", 12'({i[0] ? 1'b0 : lvl, i[0] ? !lvl : 1'b1}), 12'({irq_o, irq_oe}));
         cmp("reset_pin", 12'({i[0] ? 1'b0 : !pin_s[1], i[0] ? pin_s[1] : 1'b1}), 12'({rst_o, rst_oe}));
         i_pmcfg_host.rd(9'h106, {1'b0, d[6:4], 2'(i), d[1:0]});
         i_pmcfg_host.rd(9'h107, d);
      end
      ce = 1'b0;
      i_pmcfg_host.wr(9'h107, ~d);
      ce = 1'b1;
      i_pmcfg_host.wr(9'h0B9, 8'hFF);
      i_pmcfg_host.rd(9'h0B9, 8'h00);
      i_pmcfg_host.rd(9'h107, d);
      i_pmcfg_host.idle(3);
      cmp("reads_left", 12'h000, 12'(i_pmcfg_host.exp_q.size()));
      conclude();
   end
endmodule

// file: rtl/pmcfg_conv_dec.sv
`timescale 1ns/10ps
module pmcfg_conv_dec
   import pmcfg_pkg::*;
(
   // Clock and control
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Setting
   input wire logic [6:0] i_code,
   input wire logic i_sleep_force,
   input wire logic [1:0] i_opsel,
   input wire logic i_b_selected,
   // Outputs
   output logic [11:0] o_mv,
   output pmcfg_conv_mode_t o_mode
);
   pmcfg_conv_mode_t mode_nxt;
   wire [11:0] mv_nxt = PMCFG_CONV_BASE_MV + 12'(i_code * PMCFG_CONV_STEP_MV); // R2

   always_comb begin
      mode_nxt = '0;
      case (pmcfg_opsel_t'(i_opsel)) // R17
         PMCFG_SEL_BY_SETTING: begin
            // Sleep bit only counts while the B setting is the live one
            mode_nxt.sleep = i_b_selected & i_sleep_force; // R1
            mode_nxt.sync = i_b_selected & ~i_sleep_force; // R1
         end
         PMCFG_SEL_SLEEP: mode_nxt.sleep = 1'b1;
         PMCFG_SEL_SYNC: mode_nxt.sync = 1'b1;
         PMCFG_SEL_AUTO: mode_nxt.autom = 1'b1;
         default: mode_nxt = '0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_mv <= PMCFG_CONV_BASE_MV;
         o_mode <= '0;
      end else if (i_ce) begin
         o_mv <= mv_nxt;
         o_mode <= mode_nxt;
      end
   end
endmodule

// file: rtl/pmcfg_linreg_dec.sv
`timescale 1ns/10ps
module pmcfg_linreg_dec
   import pmcfg_pkg::*;
(
   // Clock and control
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Setting
   input wire logic [5:0] i_code,
   input wire logic i_sleep_force,
   input wire logic i_b_selected,
   // Outputs
   output logic [11:0] o_mv,
   output logic o_sleep
);
   wire [5:0] code_lo = (i_code < PMCFG_LIN_CODE_MIN) ? PMCFG_LIN_CODE_MIN : i_code; // R4
   wire [5:0] code_cl = (code_lo > PMCFG_LIN_CODE_MAX) ? PMCFG_LIN_CODE_MAX : code_lo; // R4
   wire [5:0] steps = code_cl - PMCFG_LIN_CODE_MIN;
   wire [11:0] mv_nxt = PMCFG_LIN_BASE_MV + 12'(steps * PMCFG_LIN_STEP_MV); // R3
   wire sleep_nxt = i_sleep_force & i_b_selected; // R5

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_mv <= PMCFG_LIN_BASE_MV;
         o_sleep <= 1'b0;
      end else if (i_ce) begin
         o_mv <= mv_nxt;
         o_sleep <= sleep_nxt;
      end
   end
endmodule

// file: rtl/pmcfg_pkg.sv
package pmcfg_pkg;

   // ==========================================================
   // Register map (byte offsets on the serial link)
   // ==========================================================
   localparam logic [8:0] PMCFG_OFS_CONV2_B = 9'h0B8;
   localparam logic [8:0] PMCFG_OFS_LINREG1_B = 9'h0BA;
   localparam logic [8:0] PMCFG_OFS_LINREG2_B = 9'h0BB;
   localparam logic [8:0] PMCFG_OFS_LINREG3_B = 9'h0BC;
   localparam logic [8:0] PMCFG_OFS_LINREG4_B = 9'h0BD;
   localparam logic [8:0] PMCFG_OFS_LINK_ADDR = 9'h105;
   localparam logic [8:0] PMCFG_OFS_PIN_LINK = 9'h106;
   localparam logic [8:0] PMCFG_OFS_FAULT_CFG = 9'h107;
   localparam logic [8:0] PMCFG_OFS_CLK_CFG = 9'h108;

   // ==========================================================
   // Reset values and masks
   // ==========================================================
   localparam logic [7:0] PMCFG_RST_ZERO = 8'h00;
   localparam logic [3:0] PMCFG_RST_ADDR_NIBBLE = 4'h5;
   localparam logic [7:0] PMCFG_PIN_LINK_WMASK = 8'h7F;
   localparam logic [2:0] PMCFG_ADDR_LOW_BITS = 3'h0;
   localparam int PMCFG_NUM_LINREG = 4;

   // ==========================================================
   // Voltage codes in millivolts
   // ==========================================================
   localparam logic [11:0] PMCFG_CONV_BASE_MV = 12'h320;
   localparam logic [11:0] PMCFG_CONV_STEP_MV = 12'h014;
   localparam logic [5:0] PMCFG_LIN_CODE_MIN = 6'h02;
   localparam logic [5:0] PMCFG_LIN_CODE_MAX = 6'h38;
   localparam logic [11:0] PMCFG_LIN_BASE_MV = 12'h384;
   localparam logic [11:0] PMCFG_LIN_STEP_MV = 12'h032;
   localparam logic [11:0] PMCFG_HYST_BASE_MV = 12'h064;
   localparam logic [11:0] PMCFG_FAULT_BASE_MV = 12'h9C4;
   localparam logic [11:0] PMCFG_FAULT_STEP_MV = 12'h032;

   // ==========================================================
   // Converter operating select and resolved modes
   // ==========================================================
   typedef enum logic [1:0] {
      PMCFG_SEL_BY_SETTING = 2'b00,
      PMCFG_SEL_SLEEP = 2'b01,
      PMCFG_SEL_SYNC = 2'b10,
      PMCFG_SEL_AUTO = 2'b11
   } pmcfg_opsel_t;

   typedef struct packed {
      logic sleep;
      logic sync;
      logic autom;
   } pmcfg_conv_mode_t;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pmcfg_req_t;

endpackage

// file: rtl/pmcfg_regs.sv
`timescale 1ns/10ps

// Function
// (R1) Converter sleep bit acts only in mode zero
// (R2) Converter code: 0.80 V plus 20 mV steps
// (R3) Regulator code: 0.90 V plus 50 mV steps
// (R4) Regulator codes clamp to 0x02..0x38
// (R5) Regulator sleep bit forces low-power when B active
// (R6) Target address is nibble then three zeros
// (R7) Also answer base address plus one
// (R8) Address read-only unless fuse lock clear
// (R9) High-speed bit keeps link in high speed
// (R10) Fast-plus bit selects fast-mode-plus timing
// (R11) Interrupt polarity follows polarity bit
// (R12) Reset and interrupt push-pull or open-drain
// (R13) Hysteresis 100 to 450 mV, 50 mV steps
// (R14) Fault level 2.5 to 3.25 V, 50 mV
// (R15) One clock-invert bit per converter
// (R16) Discharge bit actively discharges converter rails
// (R17) Mode field: setting, sleep, sync, automatic
// (R18) Byte-wide registers, reserved bits written back; the code clears pin/link bit 7 on write
module pmcfg_regs
   import pmcfg_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Byte access from the link engine
   input wire pmcfg_req_t i_req,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_hit,
   // Link address match
   input wire logic [6:0] i_link_addr,
   output logic o_addr_match,
   output logic [6:0] o_target_addr,
   // Fuse and setting select
   input wire logic i_fuse_config_lock,
   input wire logic i_b_selected,
   input wire logic [1:0] i_conv_operating_select,
   // Link options
   output logic o_link_high_speed_fixed,
   output logic o_link_fast_plus_timing,
   output logic o_link_supply_select,
   output logic o_control_input_supply_select,
   // Interrupt and reset pins
   input wire logic i_irq_event,
   input wire logic i_sys_reset_assert,
   output logic o_irq_out_n_o,
   output logic o_irq_out_n_oe,
   output logic o_sys_reset_out_n_o,
   output logic o_sys_reset_out_n_oe,
   // Supply fault comparator
   output logic [11:0] o_undervolt_hysteresis_mv,
   output logic [11:0] o_undervolt_threshold_mv,
   // Converter controls
   output logic [11:0] o_conv_b_mv,
   output pmcfg_conv_mode_t o_conv_mode,
   output logic o_conv1_clock_invert,
   output logic o_conv2_clock_invert,
   output logic o_conv3_clock_invert,
   output logic o_rail_active_discharge,
   // Linear regulators
   output logic [PMCFG_NUM_LINREG*12-1:0] o_linreg_b_mv,
   output logic [PMCFG_NUM_LINREG-1:0] o_linreg_sleep
);

   // ==========================================================
   // Storage
   // ==========================================================
   logic [7:0] conv2_setting_b_r;
   logic [7:0] linreg_setting_b_r [PMCFG_NUM_LINREG];
   logic [3:0] target_address_high_nibble_r;
   logic [7:0] pin_and_link_config_r;
   logic [7:0] supply_fault_config_r;
   logic [7:0] converter_clock_config_r;
   logic [7:0] rdata_nxt;

   // ==========================================================
   // Address decode
   // ==========================================================
   wire wr = i_req.wr & i_ce;
   wire sel_conv2 = (i_req.addr == PMCFG_OFS_CONV2_B);
   wire sel_addr = (i_req.addr == PMCFG_OFS_LINK_ADDR);
   wire sel_pin = (i_req.addr == PMCFG_OFS_PIN_LINK);
   wire sel_fault = (i_req.addr == PMCFG_OFS_FAULT_CFG);
   wire sel_clk = (i_req.addr == PMCFG_OFS_CLK_CFG);
   wire [PMCFG_NUM_LINREG-1:0] sel_lin;
   wire sel_any_lin = |sel_lin;
   wire addr_wr_ok = wr & sel_addr & ~i_fuse_config_lock; // R8

   // ==========================================================
   // Byte registers, full byte kept so reserved bits read back, except pin/link bit 7 and the address low nibble
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         conv2_setting_b_r <= PMCFG_RST_ZERO;
         target_address_high_nibble_r <= PMCFG_RST_ADDR_NIBBLE;
         pin_and_link_config_r <= PMCFG_RST_ZERO;
         supply_fault_config_r <= PMCFG_RST_ZERO;
         converter_clock_config_r <= PMCFG_RST_ZERO;
      end else begin
         if (wr && sel_conv2)
            conv2_setting_b_r <= i_req.wdata; // R18
         if (addr_wr_ok)
            target_address_high_nibble_r <= i_req.wdata[7:4]; // R8
         if (wr && sel_pin)
            pin_and_link_config_r <= i_req.wdata & PMCFG_PIN_LINK_WMASK;
         if (wr && sel_fault)
            supply_fault_config_r <= i_req.wdata;
         if (wr && sel_clk)
            converter_clock_config_r <= i_req.wdata;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PMCFG_NUM_LINREG; g++) begin : g_lin
         assign sel_lin[g] = (i_req.addr == PMCFG_OFS_LINREG1_B + 9'(g));
         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               linreg_setting_b_r[g] <= PMCFG_RST_ZERO;
            end else if (wr && sel_lin[g]) begin
               linreg_setting_b_r[g] <= i_req.wdata; // R18
            end
         end
         pmcfg_linreg_dec u_dec (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_ce(i_ce),
            .i_code(linreg_setting_b_r[g][5:0]),
            .i_sleep_force(linreg_setting_b_r[g][7]),
            .i_b_selected(i_b_selected),
            .o_mv(o_linreg_b_mv[g*12 +: 12]),
            .o_sleep(o_linreg_sleep[g])
         );
      end
   endgenerate

   // ==========================================================
   // Read path
   // ==========================================================
   always_comb begin
      rdata_nxt = PMCFG_RST_ZERO;
      if (sel_conv2)
         rdata_nxt = conv2_setting_b_r;
      if (sel_addr)
         rdata_nxt = {target_address_high_nibble_r, 4'h0};
      if (sel_pin)
         rdata_nxt = pin_and_link_config_r;
      if (sel_fault)
         rdata_nxt = supply_fault_config_r;
      if (sel_clk)
         rdata_nxt = converter_clock_config_r;
      for (int i = 0; i < PMCFG_NUM_LINREG; i++) begin
         if (sel_lin[i])
            rdata_nxt = linreg_setting_b_r[i];
      end
   end

   assign o_hit = sel_conv2 | sel_addr | sel_pin | sel_fault | sel_clk | sel_any_lin;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= PMCFG_RST_ZERO;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rdata <= rdata_nxt;
         o_rvalid <= i_req.rd;
      end
   end

   // ==========================================================
   // Link address and speed options
   // ==========================================================
   assign o_target_addr = {target_address_high_nibble_r, PMCFG_ADDR_LOW_BITS}; // R6
   // Low bit ignored: base and base plus one both match
   assign o_addr_match = (i_link_addr[6:1] == o_target_addr[6:1]); // R7
   assign o_link_high_speed_fixed = pin_and_link_config_r[6]; // R9
   assign o_link_fast_plus_timing = pin_and_link_config_r[5]; // R10
   assign o_link_supply_select = pin_and_link_config_r[4];
   assign o_control_input_supply_select = pin_and_link_config_r[0];

   // ==========================================================
   // Interrupt and reset pin drive
   // ==========================================================
   wire irq_pol_high = pin_and_link_config_r[3];
   wire open_drain = pin_and_link_config_r[2];
   wire irq_level = i_irq_event ~^ irq_pol_high; // R11
   wire irq_drive_low = ~irq_level;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_irq_out_n_o <= 1'b0;
         o_irq_out_n_oe <= 1'b0;
         o_sys_reset_out_n_o <= 1'b0;
         o_sys_reset_out_n_oe <= 1'b1;
      end else if (i_ce) begin
         // Open-drain only pulls low; the pull-up gives the high level
         o_irq_out_n_o <= open_drain ? 1'b0 : irq_level; // R12
         o_irq_out_n_oe <= open_drain ? irq_drive_low : 1'b1; // R12
         o_sys_reset_out_n_o <= open_drain ? 1'b0 : ~i_sys_reset_assert; // R12
         o_sys_reset_out_n_oe <= open_drain ? i_sys_reset_assert : 1'b1; // R12
      end
   end

   // ==========================================================
   // Supply fault comparator and converter controls
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_undervolt_hysteresis_mv <= PMCFG_HYST_BASE_MV;
         o_undervolt_threshold_mv <= PMCFG_FAULT_BASE_MV;
         o_conv1_clock_invert <= 1'b0;
         o_conv2_clock_invert <= 1'b0;
         o_conv3_clock_invert <= 1'b0;
         o_rail_active_discharge <= 1'b0;
      end else if (i_ce) begin
         o_undervolt_hysteresis_mv <= PMCFG_HYST_BASE_MV
            + 12'(supply_fault_config_r[6:4] * PMCFG_FAULT_STEP_MV); // R13
         o_undervolt_threshold_mv <= PMCFG_FAULT_BASE_MV
            + 12'(supply_fault_config_r[3:0] * PMCFG_FAULT_STEP_MV); // R14
         o_conv2_clock_invert <= converter_clock_config_r[6]; // R15
         o_conv3_clock_invert <= converter_clock_config_r[4]; // R15
         o_conv1_clock_invert <= converter_clock_config_r[3]; // R15
         o_rail_active_discharge <= converter_clock_config_r[2]; // R16
      end
   end

   pmcfg_conv_dec u_conv (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_code(conv2_setting_b_r[6:0]),
      .i_sleep_force(conv2_setting_b_r[7]),
      .i_opsel(i_conv_operating_select),
      .i_b_selected(i_b_selected),
      .o_mv(o_conv_b_mv),
      .o_mode(o_conv_mode)
   );

endmodule
